// file: ntb_event_interrupt_config.sv
`timescale 1ns/1ns
module ntb_event_interrupt_config
    import ntb_irq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire ntb_irq_pkg::reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire logic [ntb_irq_pkg::EVENT_COUNT-1:0] event_status,
    input wire logic msi_enable,
    input wire logic legacy_irq_disable,
    output ntb_irq_pkg::msg_s msg,
    input wire logic msg_ready,
    output logic irq
);
    import ntb_irq_pkg::*;

    typedef struct packed {
        action_e [EVENT_COUNT-1:0] action;
        logic [2:0] tc;
        logic [STATUS_WIDTH-1:0] status;
        logic [STATUS_WIDTH-1:0] mask;
        logic [31:0] rdata;
        msg_s msg;
    } main_state_s;

    main_state_s r;
    main_state_s n;
    req_s [EVENT_COUNT-1:0] req;
    logic [EVENT_COUNT-1:0] res_hit;
    logic [EVENT_COUNT-1:0] grant;
    logic load_w;
    logic status_rd;

    ////////////////////////////////////////////////////////////////////////
    // One action unit per event
    for (genvar i = 0; i < EVENT_COUNT; i++) begin : g_event
        event_action_unit event_action_unit_inst (
            .clock(clock),
            .rst(rst),
            .event_status(event_status[i]),
            .action(r.action[i]),
            .msi_enable(msi_enable),
            .legacy_irq_disable(legacy_irq_disable),
            .grant(grant[i]),
            .req(req[i]),
            .reserved_hit(res_hit[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read image of the configuration word; unimplemented bits read zero
    function automatic logic [31:0] cfg_word(input main_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[DOORBELL_LSB +: ACTION_WIDTH] = s.action[0];
        w[PEER_RESET_LSB +: ACTION_WIDTH] = s.action[1];
        w[PEER_POWER_LSB +: ACTION_WIDTH] = s.action[2];
        w[TC_LSB +: ACTION_WIDTH] = s.tc;
        return w;
    endfunction

    // Outputs straight from the state flops
    assign msg = r.msg;
    assign reg_rdata = r.rdata;
    assign irq = |(r.status & r.mask);
    assign load_w = !r.msg.valid || msg_ready;
    assign status_rd = reg_req.rd && reg_req.addr == STATUS_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    // Arbiter, register file and sticky status
    always_comb begin
        n = r;
        grant = '0;
        // Output slot refills when empty or taken; lowest event first
        if (load_w) begin
            n.msg.valid = 1'b0;
            for (int i = 0; i < EVENT_COUNT; i++) begin
                if (req[i].valid && grant == '0) begin
                    grant[i] = 1'b1;
                    n.msg.valid = 1'b1;
                    n.msg.kind = req[i].kind;
                    n.msg.pin = req[i].pin;
                    // Class number passes unchanged onto MSI traffic
                    n.msg.tc = (req[i].kind == MSG_MSI) ? r.tc : INTX_TC;
                    n.msg.event_idx = i[1:0];
                end
            end
        end
        // Register writes; reserved bits are not stored
        if (reg_req.wr) begin
            if (reg_req.addr == CFG_OFFSET) begin
                n.action[0] = action_e'(reg_req.wdata[DOORBELL_LSB +: ACTION_WIDTH]);
                n.action[1] = action_e'(reg_req.wdata[PEER_RESET_LSB +: ACTION_WIDTH]);
                n.action[2] = action_e'(reg_req.wdata[PEER_POWER_LSB +: ACTION_WIDTH]);
                n.tc = reg_req.wdata[TC_LSB +: ACTION_WIDTH];
            end else if (reg_req.addr == MASK_OFFSET) begin
                n.mask = reg_req.wdata[STATUS_WIDTH-1:0];
            end
        end
        // Read data stands for one cycle only, unmapped reads give zero
        n.rdata = 32'h0000_0000;
        if (reg_req.rd) begin
            if (reg_req.addr == CFG_OFFSET) begin
                n.rdata = cfg_word(r);
            end else if (reg_req.addr == STATUS_OFFSET) begin
                n.rdata = {28'h000_0000, r.status};
            end else if (reg_req.addr == MASK_OFFSET) begin
                n.rdata = {28'h000_0000, r.mask};
            end else if (reg_req.addr == STATE_OFFSET) begin
                n.rdata = {24'h00_0000, event_status, 1'b0, r.msg.valid,
                           req[2].valid, req[1].valid, req[0].valid};
            end
        end
        // Read clears, but an event in the same cycle wins over the clear
        n.status = (status_rd ? STATUS_RESET : r.status) | {(|res_hit), grant};
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            r.action <= '{default: ACTION_RESET};
            r.tc <= TC_RESET;
            r.status <= STATUS_RESET;
            r.mask <= MASK_RESET;
            r.rdata <= 32'h0000_0000;
            r.msg <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_msi_enable_gate: assert property (
        $past(load_w) && msg.valid && msg.kind == MSG_MSI && !$past(msg.valid && !msg_ready)
        |-> $past(msi_enable, 2) || $past(msi_enable))
        else $error("msi sent without msi enable");

    chk_legacy_gate: assert property (
        load_w && |grant && n.msg.kind == MSG_ASSERT |-> !legacy_irq_disable)
        else $error("legacy assertion while legacy interrupts disabled");

    chk_doorbell_field: assert property (
        reg_req.wr && reg_req.addr == CFG_OFFSET
        |=> r.action[0] == $past(reg_req.wdata[14:12]))
        else $error("doorbell action field not written");

    chk_reset_field: assert property (
        reg_req.wr && reg_req.addr == CFG_OFFSET
        |=> r.action[1] == $past(reg_req.wdata[17:15]))
        else $error("peer reset action field not written");

    chk_power_field: assert property (
        reg_req.wr && reg_req.addr == CFG_OFFSET
        |=> r.action[2] == $past(reg_req.wdata[20:18]))
        else $error("peer power action field not written");

    chk_msi_class: assert property (
        load_w && |grant && n.msg.kind == MSG_MSI |=> msg.valid && msg.tc == $past(r.tc))
        else $error("msi carries wrong traffic class");

    chk_cfg_readback: assert property (
        reg_req.wr && reg_req.addr == CFG_OFFSET ##1 reg_req.rd && reg_req.addr == CFG_OFFSET && !reg_req.wr
        |=> reg_rdata[31:29] == $past(reg_req.wdata[31:29], 2) && reg_rdata[28:21] == 8'h00)
        else $error("configuration word read back wrong");

    chk_msg_hold: assert property (
        msg.valid && !msg_ready |=> msg.valid && $stable(msg))
        else $error("message changed before it was taken");

    chk_reserved_flag: assert property (
        |res_hit |=> r.status[STS_RESERVED_BIT])
        else $error("reserved action not flagged");

    chk_status_sticky: assert property (
        r.status[0] && !status_rd |=> r.status[0])
        else $error("status bit lost without a read");

    cov_msi_sent: cover property (msg.valid && msg_ready && msg.kind == MSG_MSI);
    cov_assert_negate: cover property (msg.valid && msg.kind == MSG_ASSERT ##[1:20] msg.valid && msg.kind == MSG_DEASSERT);
    cov_two_events: cover property (req[0].valid && req[2].valid);
    cov_irq_raised: cover property ($rose(irq));

endmodule

// file: ntb_irq_pkg.sv
package ntb_irq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map of the plain register port
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] STATE_OFFSET = 8'h0C;

    // Field positions inside the configuration word
    localparam int DOORBELL_LSB = 12;
    localparam int PEER_RESET_LSB = 15;
    localparam int PEER_POWER_LSB = 18;
    localparam int TC_LSB = 29;
    localparam int ACTION_WIDTH = 3;

    // Event numbering and status layout
    localparam int EVENT_COUNT = 3;
    localparam int STATUS_WIDTH = 4;
    localparam int STS_RESERVED_BIT = 3;

    ////////////////////////////////////////////////////////////////////////
    // Action codes of a per-event field
    typedef enum logic [2:0] {
        ACT_MASKED = 3'b000,
        ACT_MSI = 3'b001,
        ACT_INTA = 3'b010,
        ACT_INTB = 3'b011,
        ACT_INTC = 3'b100,
        ACT_INTD = 3'b101,
        ACT_RSVD6 = 3'b110,
        ACT_RSVD7 = 3'b111
    } action_e;

    // Kinds of outgoing interrupt message
    typedef enum logic [1:0] {
        MSG_MSI = 2'b00,
        MSG_ASSERT = 2'b01,
        MSG_DEASSERT = 2'b10
    } msg_kind_e;

    // Values after reset
    localparam action_e ACTION_RESET = ACT_MASKED;
    localparam logic [2:0] TC_RESET = 3'h0;
    localparam logic [STATUS_WIDTH-1:0] MASK_RESET = 4'h0;
    localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 4'h0;
    // Legacy wire messages always travel on class 0
    localparam logic [2:0] INTX_TC = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        msg_kind_e kind;
        logic [1:0] pin;
    } req_s;

    typedef struct packed {
        logic valid;
        msg_kind_e kind;
        logic [1:0] pin;
        logic [2:0] tc;
        logic [1:0] event_idx;
    } msg_s;

    ////////////////////////////////////////////////////////////////////////
    // Decoding shared by the event units and the checks
    function automatic logic is_intx(input action_e a);
        return (a == ACT_INTA) || (a == ACT_INTB) || (a == ACT_INTC) || (a == ACT_INTD);
    endfunction

    function automatic logic [1:0] intx_pin(input action_e a);
        logic [2:0] d;
        d = a - ACT_INTA;
        return d[1:0];
    endfunction

endpackage

// file: event_action_unit.sv
`timescale 1ns/1ns
module event_action_unit
    import ntb_irq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic event_status,
    input wire ntb_irq_pkg::action_e action,
    input wire logic msi_enable,
    input wire logic legacy_irq_disable,
    input wire logic grant,
    output ntb_irq_pkg::req_s req,
    output logic reserved_hit
);
    import ntb_irq_pkg::*;

    typedef struct packed {
        logic status_d;
        logic pend_msi;
        logic pend_asrt;
        logic pend_deas;
        logic asserted;
        logic [1:0] pin;
    } unit_state_s;

    unit_state_s s_r;
    unit_state_s s_nxt;
    logic rise;
    logic fall;

    assign rise = event_status && !s_r.status_d;
    assign fall = !event_status && s_r.status_d;
    assign reserved_hit = rise && (action == ACT_RSVD6 || action == ACT_RSVD7);

    // Request priority: a pending negation goes before anything new
    // A gate that closes in this cycle holds back a queued message at once
    always_comb begin
        req.valid = s_r.pend_deas || (s_r.pend_asrt && !legacy_irq_disable) || (s_r.pend_msi && msi_enable);
        req.pin = s_r.pin;
        if (s_r.pend_deas) begin
            req.kind = MSG_DEASSERT;
        end else if (s_r.pend_asrt && !legacy_irq_disable) begin
            req.kind = MSG_ASSERT;
        end else begin
            req.kind = MSG_MSI;
        end
    end

    // Pending message bookkeeping
    always_comb begin
        s_nxt = s_r;
        s_nxt.status_d = event_status;
        if (grant) begin
            if (s_r.pend_deas) begin
                s_nxt.pend_deas = 1'b0;
                s_nxt.asserted = 1'b0;
            end else if (s_r.pend_asrt && !legacy_irq_disable) begin
                s_nxt.pend_asrt = 1'b0;
                s_nxt.asserted = 1'b1;
            end else begin
                s_nxt.pend_msi = 1'b0;
            end
        end
        // Codes zero, six and seven queue nothing here
        if (rise) begin
            if (action == ACT_MSI && msi_enable) begin
                s_nxt.pend_msi = 1'b1;
            end
            if (is_intx(action) && !legacy_irq_disable) begin
                // An unsent negation is simply withdrawn, the wire stays up
                if (s_nxt.pend_deas) begin
                    s_nxt.pend_deas = 1'b0;
                end else begin
                    s_nxt.pend_asrt = 1'b1;
                    s_nxt.pin = intx_pin(action);
                end
            end
        end
        if (fall) begin
            // An assertion never sent needs no negation
            if (s_nxt.pend_asrt) begin
                s_nxt.pend_asrt = 1'b0;
            end else if (s_nxt.asserted) begin
                s_nxt.pend_deas = 1'b1;
            end
        end
        if (legacy_irq_disable) begin
            s_nxt.pend_asrt = 1'b0;
            if (s_nxt.asserted) begin
                s_nxt.pend_deas = 1'b1;
            end
        end
        if (!msi_enable) begin
            s_nxt.pend_msi = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_masked_silent: assert property (@(posedge clock) disable iff (rst)
        rise && action == ACT_MASKED && !req.valid |=> !req.valid)
        else $error("masked event produced a request");

    chk_msi_pending: assert property (@(posedge clock) disable iff (rst)
        rise && action == ACT_MSI && msi_enable && !req.valid ##1 msi_enable
        |-> req.valid && req.kind == MSG_MSI)
        else $error("msi action did not request an msi");

    chk_pin_select: assert property (@(posedge clock) disable iff (rst)
        rise && is_intx(action) && !legacy_irq_disable && !req.valid ##1 !legacy_irq_disable
        |-> req.valid && req.kind == MSG_ASSERT && req.pin == intx_pin($past(action)))
        else $error("legacy assertion on wrong pin");

    chk_negate_follows: assert property (@(posedge clock) disable iff (rst)
        fall && s_r.asserted && !s_r.pend_asrt && !grant |=> req.valid && req.kind == MSG_DEASSERT)
        else $error("status clear did not request a negation");

endmodule

// file: host_irq_sink.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host end of the message port: takes messages, may stall on command
module host_irq_sink
    import ntb_irq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire ntb_irq_pkg::msg_s msg,
    input wire logic stall,
    output logic msg_ready,
    output int count,
    output ntb_irq_pkg::msg_s last
);
    // Ready is a plain level; a stalled host leaves the device holding its message
    assign msg_ready = !stall;

    // Log each message at the edge where it is taken
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 0;
            last <= '0;
        end else if (msg.valid && msg_ready) begin
            count <= count + 1;
            last <= msg;
        end
    end
endmodule

// file: tb_ntb_event_interrupt_config.sv
`timescale 1ns/1ns
module tb_ntb_event_interrupt_config;
    import ntb_irq_pkg::*;
    logic clock;
    logic rst;
    reg_req_s reg_req;
    logic [31:0] reg_rdata;
    logic [EVENT_COUNT-1:0] event_status;
    logic msi_enable;
    logic legacy_irq_disable;
    msg_s msg;
    logic msg_ready;
    logic irq;
    logic stall;
    int count;
    msg_s last;
    int n_errors;
    int comparisons;
    int n_got;
    int cycles = 0;

    ntb_event_interrupt_config ntb_event_interrupt_config_inst (.clock(clock), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .event_status(event_status), .msi_enable(msi_enable),
        .legacy_irq_disable(legacy_irq_disable), .msg(msg), .msg_ready(msg_ready), .irq(irq));
    host_irq_sink host_irq_sink_inst (.clock(clock), .rst(rst), .msg(msg), .stall(stall),
        .msg_ready(msg_ready), .count(count), .last(last));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs a few hundred cycles
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] cfg_word(input logic [2:0] t, input int slot, input logic [2:0] a);
        return {t, 29'h0} | ({29'h0, a} << (DOORBELL_LSB + ACTION_WIDTH * slot));
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req <= '0;
        #1 check(what, reg_rdata, exp);
    endtask

    // Write then read with no gap, which the bus allows; data must drop after one cycle
    task automatic wr_rd_chk(input string what, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req <= '0;
        #1 check(what, reg_rdata, exp);
        @(posedge clock);
        #1 check("rdata after read", reg_rdata, 32'h0);
    endtask

    task automatic set_ev(input int i, input logic v, input logic s);
        @(posedge clock);
        event_status[i] <= v;
        stall <= s;
    endtask

    // Bounded wait for the next message taken by the host
    task automatic expect_msg(input msg_kind_e k, input logic [1:0] p, input logic [2:0] t, input logic [1:0] idx);
        int w;
        w = 0;
        while (count == n_got && w < 20) begin
            @(posedge clock);
            #1 w++;
        end
        check("msg count", count, n_got + 1);
        check("msg kind tc event", {25'h0, last.kind, last.tc, last.event_idx}, {25'h0, k, t, idx});
        if (k != MSG_MSI)
            check("msg pin", {30'h0, last.pin}, {30'h0, p});
        n_got = count;
    endtask

    task automatic expect_none(input int n);
        repeat (n) @(posedge clock);
        #1 check("stray msg", count, n_got);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios; actions are only rewritten while every event is low
    task automatic test_reset();
        #1 check("rdata idle", reg_rdata, 32'h0);
        check("irq idle", {31'h0, irq}, 32'h0);
        check("msg idle", {31'h0, msg.valid}, 32'h0);
        rd_chk("cfg reset", CFG_OFFSET, 32'h0);
        rd_chk("mask reset", MASK_OFFSET, 32'h0);
    endtask

    task automatic test_fields();
        wr_rd_chk("cfg fields", CFG_OFFSET, 32'hFFFFFFFF, 32'hE01FF000);
        wr_reg(CFG_OFFSET, 32'h0);
        rd_chk("cfg cleared", CFG_OFFSET, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
    endtask

    task automatic test_msi_tc();
        for (int t = 0; t < 8; t++) begin
            wr_reg(CFG_OFFSET, cfg_word(3'(t), 0, ACT_MSI));
            set_ev(0, 1'b1, 1'b0);
            expect_msg(MSG_MSI, 2'h0, 3'(t), 2'h0);
            set_ev(0, 1'b0, 1'b0);
            expect_none(4);
        end
    endtask

    // Every legacy code on every event; the INTD pass is stalled by the host
    task automatic test_intx();
        for (int i = 0; i < EVENT_COUNT; i++) begin
            for (int c = 2; c < 6; c++) begin
                wr_reg(CFG_OFFSET, cfg_word(3'h7, i, 3'(c)));
                set_ev(i, 1'b1, c == 5);
                if (c == 5) begin
                    expect_none(6);
                    check("held while stalled", {31'h0, msg.valid}, 32'h1);
                    rd_chk("state stalled", STATE_OFFSET, 32'h8 | (32'h1 << (5 + i)));
                    set_ev(i, 1'b1, 1'b0);
                end
                expect_msg(MSG_ASSERT, 2'(c - 2), INTX_TC, 2'(i));
                set_ev(i, 1'b0, 1'b0);
                expect_msg(MSG_DEASSERT, 2'(c - 2), INTX_TC, 2'(i));
            end
        end
    endtask

    task automatic test_blocked();
        logic [2:0] codes [3] = '{ACT_MASKED, ACT_RSVD6, ACT_RSVD7};
        rd_chk("status drain", STATUS_OFFSET, 32'h7);
        for (int j = 0; j < 3; j++) begin
            wr_reg(CFG_OFFSET, cfg_word(3'h0, 0, codes[j]));
            set_ev(0, 1'b1, 1'b0);
            expect_none(8);
            rd_chk("reserved hit", STATUS_OFFSET, (codes[j] != 3'h0) ? 32'h8 : 32'h0);
            set_ev(0, 1'b0, 1'b0);
            expect_none(4);
        end
    endtask

    task automatic test_gating();
        @(posedge clock) msi_enable <= 1'b0;
        wr_reg(CFG_OFFSET, cfg_word(3'h3, 1, ACT_MSI));
        set_ev(1, 1'b1, 1'b0);
        expect_none(8);
        set_ev(1, 1'b0, 1'b0);
        @(posedge clock) msi_enable <= 1'b1;
        legacy_irq_disable <= 1'b1;
        wr_reg(CFG_OFFSET, cfg_word(3'h0, 2, ACT_INTC));
        set_ev(2, 1'b1, 1'b0);
        expect_none(8);
        set_ev(2, 1'b0, 1'b0);
        expect_none(8);
        @(posedge clock) legacy_irq_disable <= 1'b0;
    endtask

    // Raise, clear by reading, then mask the interrupt line
    task automatic test_irq();
        wr_reg(MASK_OFFSET, 32'h1);
        rd_chk("mask back", MASK_OFFSET, 32'h1);
        wr_reg(CFG_OFFSET, cfg_word(3'h0, 0, ACT_INTA));
        set_ev(0, 1'b1, 1'b0);
        expect_msg(MSG_ASSERT, 2'h0, INTX_TC, 2'h0);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd_chk("status read", STATUS_OFFSET, 32'h1);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr_reg(MASK_OFFSET, 32'h0);
        set_ev(0, 1'b0, 1'b0);
        expect_msg(MSG_DEASSERT, 2'h0, INTX_TC, 2'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd_chk("status masked", STATUS_OFFSET, 32'h1);
    endtask

    // Two events at once: lowest index goes first, MSI keeps its class
    task automatic test_two();
        wr_reg(CFG_OFFSET, cfg_word(3'h5, 0, ACT_MSI) | cfg_word(3'h5, 2, ACT_INTA));
        @(posedge clock) event_status <= 3'b101;
        expect_msg(MSG_MSI, 2'h0, 3'h5, 2'h0);
        expect_msg(MSG_ASSERT, 2'h0, INTX_TC, 2'h2);
        rd_chk("status both", STATUS_OFFSET, 32'h5);
        @(posedge clock) event_status <= 3'b000;
        expect_msg(MSG_DEASSERT, 2'h0, INTX_TC, 2'h2);
        expect_none(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        reg_req = '0;
        event_status = '0;
        msi_enable = 1'b1;
        legacy_irq_disable = 1'b0;
        stall = 1'b0;
        n_errors = 0;
        comparisons = 0;
        n_got = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_reset();
        test_fields();
        test_msi_tc();
        test_intx();
        test_blocked();
        test_gating();
        test_irq();
        test_two();
        wrap_up();
    end
endmodule
